//--- src/pmc_top.sv
// Power management control block with classic Wishbone slave
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module pmc_top
	import pmc_pkg::*;
#(
	parameter int XRST_CYCLES  = pmc_pkg::XRST_CYC,
	parameter int PULSE_CYCLES = pmc_pkg::PULSE_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// Event sources from the pins
	input  wire logic        magic_evt_i,
	input  wire logic        energy_evt_i,
	// Transceiver reset, wake pin, interrupt
	output logic             xcvr_rst_o,
	output logic             wake_pin_o,
	output logic             wake_pin_oe_o,
	output logic             irq_o
);
	import pmc_pkg::*;

	// ********************
	// Synchronised inputs
	// ********************
	logic magic_s;
	logic energy_s;

	pmc_sync u_sync_magic (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.async_i(magic_evt_i),
		.sync_o (magic_s)
	);

	pmc_sync u_sync_energy (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.async_i(energy_evt_i),
		.sync_o (energy_s)
	);

	// ********************
	// State
	// ********************
	pmc_state_t state_q, state_d;
	logic [1:0]  ps_q, ps_d;
	pmc_cfg_t    cfg_q, cfg_d;
	logic [1:0]  cause_q, cause_d;
	logic [1:0]  src_q, src_d;
	logic        ready_q, ready_d;
	logic        read_seen_q, read_seen_d;
	logic        xrst_q, xrst_d;
	logic [31:0] xcnt_q, xcnt_d;
	logic [31:0] scnt_q, scnt_d;
	logic [31:0] pcnt_q, pcnt_d;
	logic        pin_act_q, pin_act_d;
	logic [IRQ_W-1:0] sts_q, sts_d;
	logic [IRQ_W-1:0] msk_q, msk_d;
	logic        ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic        pin_q, pin_d;
	logic        pin_oe_q, pin_oe_d;
	logic        irq_q, irq_d;
	logic        magic_q, energy_q;

	logic        req;
	logic        wr;
	logic        rd;
	logic        wr_ok;
	logic        magic_rise;
	logic        energy_rise;
	logic        wake_evt;
	logic [IRQ_W-1:0] sts_set;

	function automatic logic lane_bit(input logic [3:0] sel, input int pos);
		lane_bit = sel[pos / 8];
	endfunction

	function automatic logic [31:0] pctl_word(input logic [1:0] ps, input logic xr, input pmc_cfg_t c,
	                                          input logic [1:0] ca, input logic rdy);
		pctl_word = 32'h0;
		pctl_word[PS_HI:PS_LO] = ps;
		pctl_word[XRST_BIT] = xr;
		pctl_word[MWAKE_BIT] = c.mwake;
		pctl_word[EWAKE_BIT] = c.ewake;
		pctl_word[DRIVE_BIT] = c.drive;
		pctl_word[CAUSE_HI:CAUSE_LO] = ca;
		pctl_word[PULSE_BIT] = c.pulse;
		pctl_word[POL_BIT] = c.pol;
		pctl_word[PIN_EN_BIT] = c.pin_en;
		pctl_word[READY_BIT] = rdy;
	endfunction

	assign req = cyc_i && stb_i && !ack_q;
	assign wr = req && we_i;
	assign rd = req && !we_i;
	// Writes count only after a read, and only byte test while unready
	assign wr_ok = wr && read_seen_q && ready_q;
	assign magic_rise = magic_s && !magic_q;
	assign energy_rise = energy_s && !energy_q;

	// ********************
	// Next state
	// ********************
	always_comb begin
		state_d = state_q;
		ps_d = ps_q;
		cfg_d = cfg_q;
		cause_d = cause_q;
		src_d = src_q;
		ready_d = ready_q;
		read_seen_d = read_seen_q;
		xrst_d = xrst_q;
		xcnt_d = xcnt_q;
		scnt_d = scnt_q;
		pcnt_d = pcnt_q;
		pin_act_d = pin_act_q;
		sts_d = sts_q;
		msk_d = msk_q;
		ack_d = req;
		rdat_d = 32'h0;
		sts_set = '0;
		wake_evt = 1'b0;

		if (rd) begin
			read_seen_d = 1'b1;
		end

		// Software release first, so an event in the same cycle wins
		if (wr_ok && adr_i == ADDR_EVENT_SRC && lane_bit(sel_i, 0)) begin
			src_d = src_q & ~dat_i[1:0];
		end

		// Event sources latch while enabled
		if (cfg_q.mwake && magic_rise) begin
			src_d[CAUSE_FRAME] = 1'b1;
			wake_evt = 1'b1;
		end
		if (cfg_q.ewake && energy_rise) begin
			src_d[CAUSE_ENERGY] = 1'b1;
			wake_evt = 1'b1;
		end
		sts_set[IRQ_WAKE_BIT] = wake_evt;

		// Cause clear needs ready and cleared sources; set wins
		cause_d = cause_q;
		if (wr_ok && adr_i == ADDR_POWER_CTRL && lane_bit(sel_i, CAUSE_LO) && state_q == ST_AWAKE) begin
			cause_d = cause_q & ~(dat_i[CAUSE_HI:CAUSE_LO] & ~src_q);
		end
		cause_d = cause_d | (wake_evt ? src_d : 2'h0);

		// Wake pin pulse and static activity
		if (wake_evt) begin
			pin_act_d = 1'b1;
			pcnt_d = 32'(PULSE_CYCLES);
		end else if (cfg_q.pulse && pin_act_q) begin
			if (pcnt_q <= 32'h1) begin
				pin_act_d = 1'b0;
			end else begin
				pcnt_d = pcnt_q - 32'h1;
			end
		end
		if (cause_d == 2'h0 || !(cfg_d.mwake || cfg_d.ewake)) begin
			pin_act_d = 1'b0;
		end

		// Transceiver reset timer
		if (xrst_q) begin
			if (xcnt_q <= 32'h1) begin
				xrst_d = 1'b0;
				sts_set[IRQ_XDONE_BIT] = 1'b1;
			end else begin
				xcnt_d = xcnt_q - 32'h1;
			end
		end

		// Power control writes
		if (wr_ok && adr_i == ADDR_POWER_CTRL) begin
			if (lane_bit(sel_i, PS_LO) && dat_i[PS_HI:PS_LO] != 2'h3) begin
				ps_d = dat_i[PS_HI:PS_LO];
			end
			if (lane_bit(sel_i, XRST_BIT) && !xrst_q && dat_i[XRST_BIT]) begin
				xrst_d = 1'b1;
				xcnt_d = 32'(XRST_CYCLES);
			end
			if (lane_bit(sel_i, MWAKE_BIT)) begin
				cfg_d.mwake = dat_i[MWAKE_BIT];
			end
			if (lane_bit(sel_i, 0)) begin
				cfg_d.drive = dat_i[DRIVE_BIT];
				cfg_d.pulse = dat_i[PULSE_BIT];
				cfg_d.pol = dat_i[POL_BIT];
				cfg_d.pin_en = dat_i[PIN_EN_BIT];
			end
			if (lane_bit(sel_i, EWAKE_BIT)) begin
				cfg_d.ewake = dat_i[EWAKE_BIT];
			end
		end
		if (wr_ok && adr_i == ADDR_IRQ_MASK && lane_bit(sel_i, 0)) begin
			msk_d = dat_i[IRQ_W-1:0];
		end
		sts_d = sts_q;
		if (wr_ok && adr_i == ADDR_IRQ_STATUS && lane_bit(sel_i, 0)) begin
			sts_d = sts_q & ~dat_i[IRQ_W-1:0];
		end
		sts_d = sts_d | sts_set;

		// Power state sequencing
		case (state_q)
			ST_AWAKE: begin
				if (ps_d != PS_FULL) begin
					state_d = ST_SLEEP;
					ready_d = 1'b0;
				end
			end
			ST_SLEEP: begin
				// Any byte test write wakes, even before the first read
				if (wr && adr_i == ADDR_BYTE_TEST) begin
					state_d = ST_SETTLE;
					scnt_d = 32'(STABLE_CYC);
				end
			end
			ST_SETTLE: begin
				if (scnt_q <= 32'h1) begin
					state_d = ST_AWAKE;
					ps_d = PS_FULL;
					ready_d = 1'b1;
					read_seen_d = 1'b0;
				end else begin
					scnt_d = scnt_q - 32'h1;
				end
			end
			default: begin
				state_d = ST_AWAKE;
			end
		endcase

		// Read mux
		if (rd) begin
			case (adr_i)
				ADDR_POWER_CTRL: rdat_d = pctl_word(ps_q, xrst_q, cfg_q, cause_q, ready_q);
				ADDR_BYTE_TEST: rdat_d = BYTE_TEST_VALUE;
				ADDR_IRQ_STATUS: rdat_d = {30'h0, sts_q};
				ADDR_IRQ_MASK: rdat_d = {30'h0, msk_q};
				ADDR_EVENT_SRC: rdat_d = {30'h0, src_q};
				default: rdat_d = 32'h0;
			endcase
		end
	end

	// ********************
	// Output encoding
	// ********************
	always_comb begin
		pin_d = 1'b0;
		pin_oe_d = 1'b0;
		if (cfg_q.drive) begin
			// Push-pull always drives, level from polarity
			pin_oe_d = 1'b1;
			pin_d = (pin_act_q && cfg_q.pin_en) ? cfg_q.pol : !cfg_q.pol;
		end else begin
			// Open-drain pulls low only when active
			pin_oe_d = pin_act_q && cfg_q.pin_en;
			pin_d = 1'b0;
		end
		irq_d = |(sts_d & msk_d);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_AWAKE;
			ps_q <= PS_FULL;
			cfg_q <= '0;
			cause_q <= 2'h0;
			src_q <= 2'h0;
			ready_q <= 1'b1;
			read_seen_q <= 1'b0;
			xrst_q <= 1'b0;
			xcnt_q <= 32'h0;
			scnt_q <= 32'h0;
			pcnt_q <= 32'h0;
			pin_act_q <= 1'b0;
			sts_q <= '0;
			msk_q <= '0;
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
			pin_q <= 1'b0;
			pin_oe_q <= 1'b0;
			irq_q <= 1'b0;
			magic_q <= 1'b0;
			energy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ps_q <= ps_d;
			cfg_q <= cfg_d;
			cause_q <= cause_d;
			src_q <= src_d;
			ready_q <= ready_d;
			read_seen_q <= read_seen_d;
			xrst_q <= xrst_d;
			xcnt_q <= xcnt_d;
			scnt_q <= scnt_d;
			pcnt_q <= pcnt_d;
			pin_act_q <= pin_act_d;
			sts_q <= sts_d;
			msk_q <= msk_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			pin_q <= pin_d;
			pin_oe_q <= pin_oe_d;
			irq_q <= irq_d;
			magic_q <= magic_s;
			energy_q <= energy_s;
		end
	end

	assign dat_o = rdat_q;
	assign ack_o = ack_q;
	assign xcvr_rst_o = xrst_q;
	assign wake_pin_o = pin_q;
	assign wake_pin_oe_o = pin_oe_q;
	assign irq_o = irq_q;
endmodule
`default_nettype wire

//--- src/pmc_pkg.sv
// Package for the power management control block: map, fields, states, timing
package pmc_pkg;
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_BYTE_TEST = 8'h64;
	localparam logic [7:0] ADDR_POWER_CTRL = 8'h84;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h90;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h94;
	localparam logic [7:0] ADDR_EVENT_SRC = 8'h98;

	// Power control field positions
	localparam int PS_LO = 12;
	localparam int PS_HI = 13;
	localparam int XRST_BIT = 10;
	localparam int MWAKE_BIT = 9;
	localparam int EWAKE_BIT = 8;
	localparam int DRIVE_BIT = 6;
	localparam int CAUSE_LO = 4;
	localparam int CAUSE_HI = 5;
	localparam int PULSE_BIT = 3;
	localparam int POL_BIT = 2;
	localparam int PIN_EN_BIT = 1;
	localparam int READY_BIT = 0;

	// Status and mask layout
	localparam int IRQ_WAKE_BIT = 0;
	localparam int IRQ_XDONE_BIT = 1;
	localparam int IRQ_W = 2;

	// Power state encodings
	localparam logic [1:0] PS_FULL = 2'h0;
	localparam logic [1:0] PS_FRAME = 2'h1;
	localparam logic [1:0] PS_ENERGY = 2'h2;

	// Cause bit positions within the two bit field
	localparam int CAUSE_ENERGY = 0;
	localparam int CAUSE_FRAME = 1;

	// Byte order test pattern
	localparam logic [31:0] BYTE_TEST_VALUE = 32'h87654321;

	// Timing at 40 MHz
	localparam int CLK_HZ = 40000000;
	localparam int XRST_US = 100;
	localparam int PULSE_MS = 50;
	localparam int STABLE_CYC = 16;
	localparam int XRST_CYC = (XRST_US * (CLK_HZ / 1000000));
	localparam int PULSE_CYC = (PULSE_MS * (CLK_HZ / 1000));

	typedef struct packed {
		logic pin_en;
		logic pol;
		logic pulse;
		logic drive;
		logic ewake;
		logic mwake;
	} pmc_cfg_t;

	typedef enum {ST_AWAKE, ST_SLEEP, ST_SETTLE} pmc_state_t;
endpackage

//--- src/pmc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pmc_sync (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Raw and filtered level
	input  wire logic async_i,
	output logic      sync_o
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic       level_q;
	logic       level_d;

	always_comb begin
		stage_d = {stage_q[1:0], async_i};
		level_d = level_q;
		if (stage_q[1] == stage_q[2]) begin
			level_d = stage_q[2];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stage_q <= 3'h0;
			level_q <= 1'b0;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign sync_o = level_q;
endmodule
`default_nettype wire

//--- bench/pmc_top_asserts.sv
// Checker of bus answers, transceiver reset timing and state reads
`timescale 1ns/1ps
`default_nettype none
module pmc_asserts
	import pmc_pkg::*;
#(
	parameter int XRST_CYCLES = 20
) (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Bus and reset output
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        xcvr_rst_o
);
	int   xr_cnt_q;
	int   xr_cnt_d;
	logic rd_q;
	logic rd_d;
	logic wx_q;
	logic wx_d;
	always_comb begin
		xr_cnt_d = xcvr_rst_o ? xr_cnt_q + 1 : 0;
		rd_d = cyc_i && stb_i && !ack_o && !we_i && adr_i == ADDR_POWER_CTRL;
		wx_d = cyc_i && stb_i && !ack_o && we_i && adr_i == ADDR_POWER_CTRL && dat_i[XRST_BIT];
	end
	always_ff @(posedge clk_i) begin
		xr_cnt_q <= rst_i ? 0 : xr_cnt_d;
		rd_q <= rst_i ? 1'b0 : rd_d;
		wx_q <= rst_i ? 1'b0 : wx_d;
	end
	// ****************
	// Properties
	// ****************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req; cyc_i && stb_i && !ack_o; endsequence
	sequence s_ctl_rd; rd_q && ack_o; endsequence
	property p_ack_one; s_req |=> ack_o; endproperty
	property p_ack_drop; ack_o |=> !ack_o; endproperty
	property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
	property p_xrst_start; $rose(xcvr_rst_o) |-> wx_q && ack_o; endproperty
	property p_xrst_len; $fell(xcvr_rst_o) |-> xr_cnt_q == XRST_CYCLES; endproperty
	property p_xrst_max; xr_cnt_q <= XRST_CYCLES; endproperty
	property p_state_code; s_ctl_rd |-> dat_o[PS_HI:PS_LO] != 2'h3; endproperty
	property p_sleep_unready; s_ctl_rd ##0 (dat_o[PS_HI:PS_LO] != PS_FULL) |-> !dat_o[READY_BIT]; endproperty
	a_ack_one: assert property (p_ack_one) else $error("request not answered next cycle");
	a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
	a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
	a_xrst_start: assert property (p_xrst_start) else $error("reset rose without write");
	a_xrst_len: assert property (p_xrst_len) else $error("reset hold length wrong");
	a_xrst_max: assert property (p_xrst_max) else $error("reset held too long");
	a_state_code: assert property (p_state_code) else $error("reserved state read");
	a_sleep_unready: assert property (p_sleep_unready) else $error("ready while sleeping");
endmodule
bind pmc_top pmc_asserts #(.XRST_CYCLES(XRST_CYCLES)) pmc_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .xcvr_rst_o(xcvr_rst_o));
`default_nettype wire

//--- bench/pmc_sys_model.sv
// Model of the system power side: event sources and pulled-up wake line
`timescale 1ns/1ps
`default_nettype none
module pmc_sys_model (
	// Clock and bench requests
	input  wire logic clk_i,
	input  wire logic magic_req_i,
	input  wire logic energy_req_i,
	// Wake pin from the device
	input  wire logic pin_i,
	input  wire logic pin_oe_i,
	// Event levels and resolved line
	output logic      magic_o,
	output logic      energy_o,
	output logic      line_o
);
	// Pull-up so a released open-drain pin reads high
	assign line_o = pin_oe_i ? pin_i : 1'b1;
	always_ff @(posedge clk_i) begin
		magic_o <= magic_req_i;
		energy_o <= energy_req_i;
	end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench of the power management control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pmc_pkg::*;
	localparam int XR = 20;
	localparam int PL = 50;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, xcvr_rst_o, wake_pin_o, wake_pin_oe_o, irq_o;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, q;
	logic        magic_req, energy_req, magic_evt, energy_evt, wake_line;
	logic [3:0]  lanes = 4'hf;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          tick = 0;
	int          t0, t1;
	pmc_top #(.XRST_CYCLES(XR), .PULSE_CYCLES(PL)) pmc_top_i (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .magic_evt_i(magic_evt), .energy_evt_i(energy_evt),
		.xcvr_rst_o(xcvr_rst_o), .wake_pin_o(wake_pin_o), .wake_pin_oe_o(wake_pin_oe_o), .irq_o(irq_o));
	pmc_sys_model pmc_sys_model_i (.clk_i(clk_i), .magic_req_i(magic_req), .energy_req_i(energy_req),
		.pin_i(wake_pin_o), .pin_oe_i(wake_pin_oe_o), .magic_o(magic_evt), .energy_o(energy_evt),
		.line_o(wake_line));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) tick <= tick + 1;
	// ****************
	// Shared tasks
	// ****************
	task automatic results();
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic lose();
		n_mismatch++;
		results();
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= lanes;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) lose();
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	// Waits on line (0), reset output (1) or interrupt (2)
	task automatic wt(input int s, input logic v, output int t);
		int n;
		n = 0;
		while ((s == 1 ? xcvr_rst_o : s == 2 ? irq_o : wake_line) !== v) begin
			@(posedge clk_i);
			n++;
			if (n > 200) lose();
		end
		t = tick;
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_first();
		wb(1'b1, ADDR_POWER_CTRL, 32'h200);
		wb(1'b0, ADDR_POWER_CTRL, 32'h0);
		chk("ctl after early write", 32'h1, q);
		wb(1'b0, ADDR_BYTE_TEST, 32'h0);
		chk("byte test", BYTE_TEST_VALUE, q);
		wb(1'b1, 8'ha0, 32'hffffffff);
		wb(1'b0, 8'ha0, 32'h0);
		chk("unmapped", 32'h0, q);
		// Only byte one enabled: magic enable lands, pin fields stay clear
		lanes = 4'h2;
		wb(1'b1, ADDR_POWER_CTRL, 32'h206);
		lanes = 4'hf;
		wb(1'b0, ADDR_POWER_CTRL, 32'h0);
		chk("lane gated write", 32'h201, q);
	endtask
	task automatic t_xrst();
		wb(1'b1, ADDR_POWER_CTRL, 32'h400);
		t0 = tick;
		chk("xcvr out", 32'h1, {31'h0, xcvr_rst_o});
		wb(1'b1, ADDR_POWER_CTRL, 32'h400);
		wb(1'b0, ADDR_POWER_CTRL, 32'h0);
		chk("xcvr bit", 32'h1, {31'h0, q[XRST_BIT]});
		wt(1, 1'b0, t1);
		chk("xcvr hold", XR, t1 - t0);
		wb(1'b0, ADDR_POWER_CTRL, 32'h0);
		chk("xcvr clear", 32'h1, q);
		chk("irq masked", 32'h0, {31'h0, irq_o});
		wb(1'b1, ADDR_IRQ_MASK, 32'h3);
		wt(2, 1'b1, t1);
		wb(1'b1, ADDR_IRQ_STATUS, 32'h2);
		wt(2, 1'b0, t1);
		wb(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk("status cleared", 32'h0, q);
	endtask
	task automatic t_wake();
		wb(1'b1, ADDR_IRQ_MASK, 32'h1);
		wb(1'b1, ADDR_POWER_CTRL, 32'h200);
		magic_req <= 1'b1;
		wt(2, 1'b1, t1);
		chk("line without pin enable", 32'h1, {31'h0, wake_line});
		wb(1'b0, ADDR_POWER_CTRL, 32'h0);
		chk("cause frame", 32'h221, q);
		magic_req <= 1'b0;
		wb(1'b1, ADDR_POWER_CTRL, 32'h220);
		wb(1'b0, ADDR_POWER_CTRL, 32'h0);
		chk("cause held by source", 32'h221, q);
		wb(1'b1, ADDR_EVENT_SRC, 32'h3);
		wb(1'b1, ADDR_POWER_CTRL, 32'h220);
		wb(1'b1, ADDR_IRQ_STATUS, 32'h1);
		wb(1'b0, ADDR_POWER_CTRL, 32'h0);
		chk("cause cleared", 32'h201, q);
		chk("irq cleared", 32'h0, {31'h0, irq_o});
		wb(1'b1, ADDR_POWER_CTRL, 32'h206);
		magic_req <= 1'b1;
		wt(0, 1'b0, t1);
		chk("open drain driving", 32'h1, {31'h0, wake_pin_oe_o});
		wb(1'b1, ADDR_POWER_CTRL, 32'h6);
		wt(0, 1'b1, t1);
		magic_req <= 1'b0;
	endtask
	task automatic t_pulse();
		for (int p = 0; p < 2; p++) begin
			wb(1'b1, ADDR_POWER_CTRL, 32'h14a | 32'(p << 2));
			wb(1'b0, ADDR_POWER_CTRL, 32'h0);
			chk("push pull idle", {31'h0, ~p[0]}, {31'h0, wake_line});
		end
		energy_req <= 1'b1;
		wt(0, 1'b1, t0);
		wt(0, 1'b0, t1);
		chk("pulse length", PL, t1 - t0);
		wb(1'b0, ADDR_POWER_CTRL, 32'h0);
		chk("cause both", 32'h17f, q);
		energy_req <= 1'b0;
	endtask
	task automatic t_sleep();
		int n;
		wb(1'b1, ADDR_EVENT_SRC, 32'h3);
		wb(1'b1, ADDR_POWER_CTRL, 32'h30);
		for (int i = 1; i < 3; i++) begin
			wb(1'b1, ADDR_POWER_CTRL, 32'(i) << PS_LO);
			wb(1'b0, ADDR_POWER_CTRL, 32'h0);
			chk("sleep state", 32'(i) << PS_LO, q);
			wb(1'b1, ADDR_BYTE_TEST, 32'h0);
			n = 0;
			do begin
				wb(1'b0, ADDR_POWER_CTRL, 32'h0);
				n++;
			end while (q[READY_BIT] !== 1'b1 && n < 40);
			chk("woken", 32'h1, q);
		end
		wb(1'b1, ADDR_POWER_CTRL, 32'h3000);
		wb(1'b0, ADDR_POWER_CTRL, 32'h0);
		chk("reserved state", 32'h1, q);
	endtask
	task automatic t_rst();
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b1, ADDR_IRQ_MASK, 32'h3);
		chk("irq after reset", 32'h0, {31'h0, irq_o});
		wb(1'b0, ADDR_IRQ_MASK, 32'h0);
		chk("mask after reset", 32'h0, q);
	endtask
	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h0;
		sel_i = 4'hf;
		dat_i = 32'h0;
		magic_req = 1'b0;
		energy_req = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_first();
		t_xrst();
		t_wake();
		t_pulse();
		t_sleep();
		t_rst();
		results();
	end
endmodule
`default_nettype wire
